// File: eep_encoder_pulse_out.sv
// external encoder decode, direction mapping and scaled quadrature pulse regeneration
//
// Overview of operation
// - usage 0: motor encoder alone drives the pulses; the feedback register still counts the external encoder
// - usage 1: external encoder used, counting up counterclockwise is forward
// - usage 3: external encoder used, counting up clockwise is forward
// - usage 1 forward gives phase B lead, usage 3 forward phase A lead
// - pitch count per revolution ranges 4 to 1048576, default 32768
// - output edges per pitch ranges 1 to 4096, default 20
// - output edge rate above 6.4 Mpps raises the overspeed alarm
// - origin pulse width equals the pulse width of the phase (A or B) selected for alignment
// - origin pulse starts on a selected A or B rising or falling edge
// - rotation direction select swaps which motor direction is forward
`timescale 1ns/1ps
`default_nettype none
module eep_encoder_pulse_out
    import eep_pkg::*;
#(
    parameter int IN_STEPS_PER_PITCH = 256,
    parameter int ACC_W = 24
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_enc_a,
    input wire logic ext_enc_b,
    input wire logic ext_enc_origin,
    input wire logic motor_enc_a,
    input wire logic motor_enc_b,
    input wire logic motor_enc_origin,
    output logic quad_out_a,
    output logic quad_out_b,
    output logic origin_pulse_out,
    output logic output_overspeed_alarm,
    output logic irq
);

    localparam int NPIN = 6;
    localparam int WIN_W = $clog2(RATE_WIN_CYCLES + 1);
    localparam int RCNT_W = $clog2(RATE_EDGE_LIMIT + 2);
    localparam logic signed [ACC_W-1:0] STEP_DIV = ACC_W'(IN_STEPS_PER_PITCH);

    generate
        if (IN_STEPS_PER_PITCH < 1 || ACC_W < EDGES_W + 4 || ACC_W > 31)
        begin : g_bad_param
            $error("eep_encoder_pulse_out: unsupported IN_STEPS_PER_PITCH or ACC_W");
        end
    endgenerate

    function automatic logic [1:0] quad_phase(input logic a, input logic b);
        return {a, a ^ b};
    endfunction : quad_phase

    // returns {step, up}; a two-phase jump is illegal and dropped
    function automatic logic [1:0] quad_decode(input logic pa, input logic pb, input logic a, input logic b);
        logic [1:0] d;
        d = quad_phase(a, b) - quad_phase(pa, pb);
        return {(d == 2'h1) || (d == 2'h3), d == 2'h1};
    endfunction : quad_decode

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] pin_prev_reg;
    assign pin_in = {motor_enc_origin, motor_enc_b, motor_enc_a, ext_enc_origin, ext_enc_b, ext_enc_a};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    pin_prev_reg[gi] <= 1'b0;
                end
                else
                begin
                    sync1_reg[gi] <= pin_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    pin_prev_reg[gi] <= sync2_reg[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, answer on the second cycle of a request
    logic ack_reg;
    logic bus_wr;
    logic [2:0] cfg_usage_reg;
    logic cfg_rot_reg;
    logic [1:0] cfg_align_reg;
    logic [PITCH_W-1:0] cfg_pitch_reg;
    logic [EDGES_W-1:0] cfg_edges_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic [ST_W-1:0] status_set;
    logic [ST_W-1:0] status_next;
    logic restart_reg;
    logic [2:0] act_usage_reg;
    logic act_rot_reg;
    eep_align_type act_align_reg;
    logic [PITCH_W-1:0] act_pitch_reg;
    logic [EDGES_W-1:0] act_edges_reg;
    logic [DATA_W-1:0] feedback_reg;
    logic [DATA_W-1:0] rd_mux;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign bus_wr = avs_write & ack_reg;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    always_comb
    begin
        rd_mux = '0;
        case (avs_address)
            ADDR_CTRL: rd_mux = DATA_W'({cfg_align_reg, cfg_rot_reg, cfg_usage_reg});
            ADDR_PITCH: rd_mux = DATA_W'(cfg_pitch_reg);
            ADDR_EDGES: rd_mux = DATA_W'(cfg_edges_reg);
            ADDR_STATUS: rd_mux = DATA_W'(status_reg);
            ADDR_MASK: rd_mux = DATA_W'(mask_reg);
            ADDR_ACTIVE: rd_mux = DATA_W'({origin_pulse_out, quad_out_b, quad_out_a,
                                          act_usage_reg != USAGE_OFF, act_align_reg, act_rot_reg, act_usage_reg});
            ADDR_FEEDBACK: rd_mux = feedback_reg;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            avs_readdata <= '0;
        else if (avs_read && !ack_reg)
            avs_readdata <= rd_mux;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cfg_usage_reg <= USAGE_OFF;
            cfg_rot_reg <= 1'b0;
            cfg_align_reg <= 2'h0;
            cfg_pitch_reg <= PITCH_DEFAULT;
            cfg_edges_reg <= EDGES_DEFAULT;
            mask_reg <= '0;
        end
        else if (bus_wr)
        begin
            case (avs_address)
                ADDR_CTRL:
                begin
                    cfg_usage_reg <= avs_writedata[CTRL_USAGE_LSB +: USAGE_W];
                    cfg_rot_reg <= avs_writedata[CTRL_ROT_BIT];
                    cfg_align_reg <= avs_writedata[CTRL_ALIGN_LSB +: 2];
                end
                ADDR_PITCH: cfg_pitch_reg <= avs_writedata[PITCH_W-1:0];
                ADDR_EDGES: cfg_edges_reg <= avs_writedata[EDGES_W-1:0];
                ADDR_MASK: mask_reg <= avs_writedata[ST_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // restart: settings move to the active copy only here, never mid-run
    logic usage_ok;
    logic pitch_ok;
    logic edges_ok;
    assign usage_ok = (cfg_usage_reg == USAGE_OFF) || (cfg_usage_reg == USAGE_FWD) || (cfg_usage_reg == USAGE_REV);
    assign pitch_ok = (cfg_pitch_reg >= PITCH_MIN) && (cfg_pitch_reg <= PITCH_MAX);
    assign edges_ok = (cfg_edges_reg >= EDGES_MIN) && (cfg_edges_reg <= EDGES_MAX);

    always_ff @(posedge core_clk)
    begin
        if (reset)
            restart_reg <= 1'b1;
        else
            restart_reg <= bus_wr && avs_address == ADDR_CTRL && avs_writedata[CTRL_RESTART_BIT];
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            act_usage_reg <= USAGE_OFF;
            act_rot_reg <= 1'b0;
            act_align_reg <= ALIGN_A_RISE;
            act_pitch_reg <= PITCH_DEFAULT;
            act_edges_reg <= EDGES_DEFAULT;
        end
        else if (restart_reg)
        begin
            // reserved usage codes fall back to semi-closed operation
            act_usage_reg <= usage_ok ? cfg_usage_reg : USAGE_OFF;
            act_rot_reg <= cfg_rot_reg;
            act_align_reg <= eep_align_type'(cfg_align_reg);
            act_pitch_reg <= pitch_ok ? cfg_pitch_reg : PITCH_DEFAULT;
            act_edges_reg <= edges_ok ? cfg_edges_reg : EDGES_DEFAULT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // direction mapping and step source
    logic use_ext;
    logic is_rev;
    logic [1:0] ext_dec;
    logic [1:0] mot_dec;
    logic src_step;
    logic src_up;
    logic fwd_run;
    logic out_up;
    assign use_ext = act_usage_reg != USAGE_OFF;
    assign is_rev = act_usage_reg == USAGE_REV;
    assign ext_dec = quad_decode(pin_prev_reg[0], pin_prev_reg[1], sync2_reg[0], sync2_reg[1]);
    assign mot_dec = quad_decode(pin_prev_reg[3], pin_prev_reg[4], sync2_reg[3], sync2_reg[4]);
    assign src_step = use_ext ? ext_dec[1] : mot_dec[1];
    assign src_up = use_ext ? ext_dec[0] : mot_dec[0];
    // forward run: up-count is forward for usage 1, down-count for usage 3
    assign fwd_run = src_up ^ is_rev ^ act_rot_reg;
    // incrementing the output phase gives phase B lead
    assign out_up = fwd_run ^ is_rev;

    always_ff @(posedge core_clk)
    begin
        if (reset || restart_reg)
            feedback_reg <= '0;
        else if (ext_dec[1])
            feedback_reg <= ext_dec[0] ? feedback_reg + 32'h1 : feedback_reg - 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // scaling: each input step adds edges-per-pitch, each output step removes one pitch
    // worth of input steps; one output edge per cycle at most, so no state is skipped
    logic signed [ACC_W-1:0] acc_reg;
    logic signed [ACC_W-1:0] acc_next;
    logic signed [ACC_W-1:0] edges_s;
    logic out_fire;
    logic out_dir_up;
    assign edges_s = signed'(ACC_W'(act_edges_reg));

    always_comb
    begin
        acc_next = acc_reg;
        out_fire = 1'b0;
        out_dir_up = out_up;
        if (use_ext)
        begin
            if (acc_reg >= STEP_DIV)
            begin
                out_fire = 1'b1;
                out_dir_up = 1'b1;
                acc_next = acc_reg - STEP_DIV;
            end
            else if (acc_reg <= -STEP_DIV)
            begin
                out_fire = 1'b1;
                out_dir_up = 1'b0;
                acc_next = acc_reg + STEP_DIV;
            end
            if (src_step)
                acc_next = out_up ? acc_next + edges_s : acc_next - edges_s;
        end
        else
            out_fire = src_step;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset || restart_reg)
            acc_reg <= '0;
        else
            acc_reg <= acc_next;
    end

    logic next_a;
    logic next_b;
    // up walks 00,01,11,10: new a copies b, new b is the old a inverted
    assign next_a = out_dir_up ? quad_out_b : ~quad_out_b;
    assign next_b = out_dir_up ? ~quad_out_a : quad_out_a;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            quad_out_a <= 1'b0;
            quad_out_b <= 1'b0;
        end
        else if (out_fire)
        begin
            quad_out_a <= next_a;
            quad_out_b <= next_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output rate supervision over a fixed window
    logic [WIN_W-1:0] win_cnt_reg;
    logic [RCNT_W-1:0] rate_cnt_reg;
    logic overspeed_evt;
    assign overspeed_evt = out_fire && rate_cnt_reg == RCNT_W'(RATE_EDGE_LIMIT);

    always_ff @(posedge core_clk)
    begin
        if (reset || win_cnt_reg == WIN_W'(RATE_WIN_CYCLES - 1))
        begin
            win_cnt_reg <= '0;
            rate_cnt_reg <= '0;
        end
        else
        begin
            win_cnt_reg <= win_cnt_reg + WIN_W'(1);
            if (out_fire && rate_cnt_reg <= RCNT_W'(RATE_EDGE_LIMIT))
                rate_cnt_reg <= rate_cnt_reg + RCNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // origin pulse: armed by the encoder origin, opened and closed on edges of one phase
    eep_origin_state_type org_state_reg;
    logic org_rise;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic org_start;
    logic org_end;
    assign org_rise = use_ext ? (sync2_reg[2] & ~pin_prev_reg[2]) : (sync2_reg[5] & ~pin_prev_reg[5]);
    assign a_rise = out_fire & ~quad_out_a & next_a;
    assign a_fall = out_fire & quad_out_a & ~next_a;
    assign b_rise = out_fire & ~quad_out_b & next_b;
    assign b_fall = out_fire & quad_out_b & ~next_b;

    always_comb
    begin
        case (act_align_reg)
            ALIGN_A_RISE:
            begin
                org_start = a_rise;
                org_end = a_fall;
            end
            ALIGN_A_FALL:
            begin
                org_start = a_fall;
                org_end = a_rise;
            end
            ALIGN_B_RISE:
            begin
                org_start = b_rise;
                org_end = b_fall;
            end
            default:
            begin
                org_start = b_fall;
                org_end = b_rise;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset || restart_reg)
        begin
            org_state_reg <= ORG_IDLE;
            origin_pulse_out <= 1'b0;
        end
        else
        begin
            case (org_state_reg)
                ORG_IDLE:
                    if (org_rise)
                        org_state_reg <= ORG_ARMED;
                ORG_ARMED:
                    if (org_start)
                    begin
                        org_state_reg <= ORG_ACTIVE;
                        origin_pulse_out <= 1'b1;
                    end
                ORG_ACTIVE:
                    if (org_end)
                    begin
                        org_state_reg <= ORG_IDLE;
                        origin_pulse_out <= 1'b0;
                    end
                default:
                    org_state_reg <= ORG_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear; a set in the clearing cycle wins
    always_comb
    begin
        status_set = '0;
        status_set[ST_OVERSPEED] = overspeed_evt;
        status_set[ST_ORIGIN] = org_state_reg == ORG_ARMED && org_start;
        status_set[ST_CFG_ERR] = restart_reg && !(usage_ok && pitch_ok && edges_ok);
        status_next = status_reg;
        if (bus_wr && avs_address == ADDR_STATUS)
            status_next = status_reg & ~avs_writedata[ST_W-1:0];
        status_next = status_next | status_set;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            status_reg <= '0;
        else
            status_reg <= status_next;
    end

    assign output_overspeed_alarm = status_reg[ST_OVERSPEED];
    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_SEMI_SOURCE: assert property (@(posedge core_clk) disable iff (reset)
        (!use_ext && !mot_dec[1]) |=> ($stable(quad_out_a) && $stable(quad_out_b)))
        else $error("semi-closed output step without motor step");
    AST_USAGE_FWD_DIR: assert property (@(posedge core_clk) disable iff (reset)
        (act_usage_reg == USAGE_FWD && !act_rot_reg && ext_dec[1]) |-> (fwd_run == ext_dec[0]))
        else $error("usage 1 direction wrong");
    AST_USAGE_REV_DIR: assert property (@(posedge core_clk) disable iff (reset)
        (act_usage_reg == USAGE_REV && !act_rot_reg && ext_dec[1]) |-> (fwd_run == !ext_dec[0]))
        else $error("usage 3 direction wrong");
    AST_LEAD: assert property (@(posedge core_clk) disable iff (reset)
        (use_ext && src_step) |-> (out_up == (ext_dec[0] ^ act_rot_reg)))
        else $error("phase lead does not match direction");
    AST_STEP_GRAY: assert property (@(posedge core_clk) disable iff (reset)
        out_fire |=> (quad_out_a ^ quad_out_b ^ $past(quad_out_a) ^ $past(quad_out_b)))
        else $error("output step skipped or stalled a quadrature state");
    AST_PITCH_RANGE: assert property (@(posedge core_clk) disable iff (reset)
        (act_pitch_reg >= PITCH_MIN && act_pitch_reg <= PITCH_MAX))
        else $error("active pitch count out of range");
    AST_EDGES_RANGE: assert property (@(posedge core_clk) disable iff (reset)
        (act_edges_reg >= EDGES_MIN && act_edges_reg <= EDGES_MAX))
        else $error("active edges per pitch out of range");
    AST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        !restart_reg |=> ($stable(act_usage_reg) && $stable(act_pitch_reg) && $stable(act_edges_reg)))
        else $error("active setting changed without restart");
    AST_OVERSPEED: assert property (@(posedge core_clk) disable iff (reset)
        overspeed_evt |=> output_overspeed_alarm ##1 irq || !mask_reg[ST_OVERSPEED] || !output_overspeed_alarm)
        else $error("overspeed not flagged");
    AST_ORIGIN_START: assert property (@(posedge core_clk) disable iff (reset)
        $rose(origin_pulse_out) |-> $past(org_start))
        else $error("origin pulse not aligned to selected edge");
    AST_ORIGIN_WIDTH: assert property (@(posedge core_clk) disable iff (reset)
        ($fell(origin_pulse_out) && !$past(restart_reg)) |-> $past(org_end))
        else $error("origin pulse ended off the matching phase edge");

endmodule : eep_encoder_pulse_out
`default_nettype wire

// File: eep_encoder_pulse_out_tb.sv
// self-checking bench for the external encoder pulse regenerator
`timescale 1ns/1ps
`default_nettype none
module eep_encoder_pulse_out_tb;
    import eep_pkg::*;
    logic core_clk = 0, reset = 1, avs_read = 0, avs_write = 0, org = 0, run = 0, run_up = 1;
    logic [2:0] avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, enc_a, enc_b, qa, qb, qc, alarm, irq, sel, psel;
    logic [3:0] period = 4'h4;
    logic [2:0] cur, prev;
    logic signed [31:0] host_count, base;
    int err_count = 0, samples_checked = 0, nc;
    // only usage codes 1 and 3 are written; the faults come from pitch and edge limits
    int cu [5] = '{1, 3, 1, 1, 1};
    int cp [5] = '{3, 1048577, 32768, 32768, 1048576};
    int ce [5] = '{20, 20, 0, 4097, 4096};
    always #50 core_clk = ~core_clk;
    eep_encoder_pulse_out DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_enc_a(enc_a), .ext_enc_b(enc_b), .ext_enc_origin(org),
        // motor phases swapped: the motor counts opposite to the external encoder
        .motor_enc_a(enc_b), .motor_enc_b(enc_a), .motor_enc_origin(1'b0), .quad_out_a(qa), .quad_out_b(qb),
        .origin_pulse_out(qc), .output_overspeed_alarm(alarm), .irq(irq));
    eep_far_side far (.core_clk(core_clk), .reset(reset), .run(run), .run_up(run_up), .period(period),
        .quad_out_a(qa), .quad_out_b(qb), .enc_a(enc_a), .enc_b(enc_b), .host_count(host_count));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask : check
    // one edge passes after release so the next request never lands in the same step
    task automatic bus(input logic wr, input logic [2:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 20)
            begin
                err_count++;
                wrap_up();
            end
            @(posedge core_clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic restart(input int ctrl, input int pitch, input int edges);
        bus(1, ADDR_PITCH, pitch);
        bus(1, ADDR_EDGES, edges);
        bus(1, ADDR_CTRL, ctrl | 32'h100);
        repeat (3) @(posedge core_clk);
        base = host_count;
    endtask : restart
    task automatic steps(input int n, input logic [3:0] p);
        period <= p;
        run <= 1'b1;
        repeat (n * p) @(posedge core_clk);
        run <= 1'b0;
        repeat (30) @(posedge core_clk);
    endtask : steps
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(0, ADDR_PITCH, 0);
        check("pitch default", rd, 32'h8000);
        bus(0, ADDR_EDGES, 0);
        check("edges default", rd, 32'h14);
        bus(0, 3'h7, 0);
        check("unmapped read", rd, 32'h0);
        steps(8, 4);
        check("semi closed count", host_count, -32'sd8);
        bus(0, ADDR_ACTIVE, 0);
        check("external in use", rd[6], 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            restart((i[1] << 3) | (i[0] ? 3 : 1), 32768, 256);
            steps(8, 4);
            check("direction", host_count - base, i[1] ? -32'sd8 : 32'sd8);
            bus(0, ADDR_FEEDBACK, 0);
            check("feedback", rd, 32'h8);
            check("slow alarm", alarm, 1'b0);
        end
        bus(1, ADDR_CTRL, 32'h1);
        bus(0, ADDR_ACTIVE, 0);
        check("latched settings", rd & 32'hf, 32'hb);
        restart(1, 32768, 128);
        steps(8, 4);
        check("scaled count", host_count - base, 32'h4);
        bus(1, ADDR_MASK, 32'h4);
        for (int i = 0; i < 5; i++)
        begin
            restart(cu[i], cp[i], ce[i]);
            bus(0, ADDR_STATUS, 0);
            check("config error", rd & 32'h4, (i < 4) ? 32'h4 : 32'h0);
            check("irq raised", irq, i < 4);
            bus(1, ADDR_MASK, 32'h0);
            check("irq masked", irq, 1'b0);
            bus(1, ADDR_MASK, 32'h4);
            bus(1, ADDR_STATUS, 32'h4);
            check("irq cleared", irq, 1'b0);
        end
        for (int al = 0; al < 4; al++)
        begin
            restart(1 | (al << 4), 32768, 256);
            org <= 1'b1;
            run <= 1'b1;
            prev = {qa, qb, qc};
            nc = 0;
            repeat (80)
            begin
                @(posedge core_clk);
                cur = {qa, qb, qc};
                if (cur[0] != prev[0])
                begin
                    nc++;
                    sel = al[1] ? cur[1] : cur[2];
                    psel = al[1] ? prev[1] : prev[2];
                    check("origin edge", {psel ^ sel, sel}, {1'b1, cur[0] ^ al[0]});
                end
                prev = cur;
            end
            run <= 1'b0;
            org <= 1'b0;
            check("origin edges", nc, 2);
        end
        restart(1, 32768, 4096);
        steps(75, 2);
        check("overspeed alarm", alarm, 1'b1);
        bus(0, ADDR_STATUS, 0);
        check("overspeed status", rd[0], 1'b1);
        wrap_up();
    end
endmodule : eep_encoder_pulse_out_tb
`default_nettype wire

// File: eep_far_side.sv
// far-side model: external encoder pattern source and host quadrature counter
`timescale 1ns/1ps
`default_nettype none
module eep_far_side
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic run_up,
    input wire logic [3:0] period,
    input wire logic quad_out_a,
    input wire logic quad_out_b,
    output logic enc_a,
    output logic enc_b,
    output logic signed [31:0] host_count
);
    logic [1:0] phase_reg;
    logic [3:0] wait_reg;
    logic [1:0] seen_reg;
    // gray order 00,01,11,10 counts up; one state per step, never faster than period
    assign enc_a = phase_reg[1];
    assign enc_b = phase_reg[1] ^ phase_reg[0];
    always_ff @(posedge core_clk)
    begin
        if (reset)
            phase_reg <= 2'h0;
        else if (run && wait_reg + 4'h1 >= period)
            phase_reg <= run_up ? phase_reg + 2'h1 : phase_reg - 2'h1;
        if (reset || !run || wait_reg + 4'h1 >= period)
            wait_reg <= 4'h0;
        else
            wait_reg <= wait_reg + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // host counter: a skipped state counts as a step down, so it cannot pass unseen
    always_ff @(posedge core_clk)
    begin
        seen_reg <= {quad_out_a, quad_out_b};
        if (reset)
            host_count <= 32'sh0;
        else if (seen_reg != {quad_out_a, quad_out_b})
            host_count <= host_count + ((({quad_out_a, quad_out_a ^ quad_out_b}
                - {seen_reg[1], seen_reg[1] ^ seen_reg[0]}) == 2'h1) ? 32'sd1 : -32'sd1);
    end
endmodule : eep_far_side
`default_nettype wire

// File: eep_pkg.sv
// constants, register map and types for the external encoder pulse regenerator
package eep_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_PITCH = 3'h1;
    localparam logic [2:0] ADDR_EDGES = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_MASK = 3'h4;
    localparam logic [2:0] ADDR_ACTIVE = 3'h5;
    localparam logic [2:0] ADDR_FEEDBACK = 3'h6;
    localparam int USAGE_W = 3;
    localparam logic [2:0] USAGE_OFF = 3'h0;
    localparam logic [2:0] USAGE_FWD = 3'h1;
    localparam logic [2:0] USAGE_REV = 3'h3;
    localparam int CTRL_USAGE_LSB = 0;
    localparam int CTRL_ROT_BIT = 3;
    localparam int CTRL_ALIGN_LSB = 4;
    localparam int CTRL_RESTART_BIT = 8;
    localparam int ACT_EXT_BIT = 6;
    localparam int ACT_A_BIT = 7;
    localparam int ACT_B_BIT = 8;
    localparam int ACT_C_BIT = 9;
    localparam int PITCH_W = 21;
    localparam logic [20:0] PITCH_MIN = 21'h000004;
    localparam logic [20:0] PITCH_MAX = 21'h100000;
    localparam logic [20:0] PITCH_DEFAULT = 21'h008000;
    localparam int EDGES_W = 13;
    localparam logic [12:0] EDGES_MIN = 13'h0001;
    localparam logic [12:0] EDGES_MAX = 13'h1000;
    localparam logic [12:0] EDGES_DEFAULT = 13'h0014;
    localparam int ST_W = 3;
    localparam int ST_OVERSPEED = 0;
    localparam int ST_ORIGIN = 1;
    localparam int ST_CFG_ERR = 2;
    localparam int RATE_LIMIT_KPPS = 6400;
    localparam int RATE_WIN_NS = 10000;
    localparam int RATE_WIN_CYCLES = RATE_WIN_NS / CLK_PERIOD_NS;
    localparam int RATE_EDGE_LIMIT = RATE_LIMIT_KPPS * RATE_WIN_NS / 1000000;
    typedef enum logic [1:0] {ALIGN_A_RISE, ALIGN_A_FALL, ALIGN_B_RISE, ALIGN_B_FALL} eep_align_type;
    typedef enum logic [1:0] {ORG_IDLE, ORG_ARMED, ORG_ACTIVE} eep_origin_state_type;
endpackage : eep_pkg
